//--- src/rsw_pkg.sv
// Purpose: Shared constants and types for the reset source controller.
// Assumes: 50 MHz system clock; classic Wishbone register access.
// Notes:   Byte offsets are word aligned; registers sit in data bits 7:0.
package rsw_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_HZ          = 50_000_000;
    localparam int POR_TIMEOUT_MS  = 100;
    localparam int POR_TIMEOUT_CYC = CLK_HZ / 1000 * POR_TIMEOUT_MS;
    localparam int PIN_HOLD_CYC    = 12;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    localparam int         WDOG_BITS     = 21;
    localparam int         WDOG_EXP_BASE = 3;
    localparam int         WDOG_DIS_WIN  = 4;
    localparam logic [7:0] WDOG_KICK     = 8'ha5;
    localparam logic [7:0] WDOG_ARM      = 8'hde;
    localparam logic [7:0] WDOG_DIS      = 8'had;
    localparam logic [7:0] WDOG_LOCK     = 8'hff;
    localparam logic [2:0] WDOG_IVL_RST  = 3'h7;
    localparam int         WDOG_STAT_BIT = 4;
    localparam int         WDOG_SEL_BIT  = 7;

    ////////////////////////////////////////////////////////////////////////
    // Register map and cause register layout
    localparam int         ADR_W          = 4;
    localparam logic [3:0] WDOG_CTRL_OFS  = 4'h0;
    localparam logic [3:0] CAUSE_OFS      = 4'h4;
    localparam int         CAUSE_PIN_BIT  = 0;
    localparam int         CAUSE_POR_BIT  = 1;
    localparam int         CAUSE_LOSS_BIT = 2;
    localparam int         CAUSE_WDOG_BIT = 3;
    localparam int         CAUSE_COMP_BIT = 5;
    localparam int         CAUSE_CNV_BIT  = 6;
    localparam logic [15:0] RESET_VECTOR  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic       stb;
        logic [7:0] data;
    } rsw_wr_type;

    typedef struct packed {
        logic cnv;
        logic comp;
        logic wdog;
        logic loss;
        logic por;
        logic pin;
    } rsw_cause_type;

    typedef enum logic [1:0] {
        ST_POR     = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN     = 2'b10
    } rsw_state_type;

endpackage

//--- src/rsw_wdog.sv
// Purpose: Watchdog counter with kick, two-write disable and lockout.
// Assumes: Writes arrive as one-cycle strobes on the system clock.
// Notes:   Held in its default state while reinit is high.
`timescale 1ns/10ps
module rsw_wdog
    import rsw_pkg::*;
#(
    parameter int CNT_BITS = WDOG_BITS,
    parameter int EXP_BASE = WDOG_EXP_BASE
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       reinit,
    // Control writes and status
    input  rsw_wr_type      wr,
    output logic [7:0]      ctrl_rd,
    output logic            ovf
);

    logic                active_ff;
    logic                lock_ff;
    logic [2:0]          ivl_ff;
    logic [2:0]          arm_ff;
    logic [CNT_BITS-1:0] cnt_ff;
    logic [CNT_BITS-1:0] lim;
    logic                kick;
    logic                dis_ok;

    always_comb begin
        lim = CNT_BITS'((64'd1 << (2 * (EXP_BASE + int'(ivl_ff)))) - 64'd1);
    end

    assign kick   = wr.stb && (wr.data == WDOG_KICK);
    // Armed window still open and no lockout
    assign dis_ok = wr.stb && (wr.data == WDOG_DIS) && (arm_ff != 3'h0)
                    && !lock_ff;
    assign ctrl_rd = {3'h0, active_ff, 1'b0, ivl_ff};

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_ff <= 1'b1;
            lock_ff   <= 1'b0;
            ivl_ff    <= WDOG_IVL_RST;
        end else if (reinit) begin
            active_ff <= 1'b1;
            lock_ff   <= 1'b0;
            ivl_ff    <= WDOG_IVL_RST;
        end else if (wr.stb) begin
            if (kick)
                active_ff <= 1'b1;
            else if (dis_ok)
                active_ff <= 1'b0;
            if (wr.data == WDOG_LOCK)
                lock_ff <= 1'b1;
            if (!wr.data[WDOG_SEL_BIT])
                ivl_ff <= wr.data[2:0];
        end
    end

    // Any other write between the pair closes the window
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            arm_ff <= 3'h0;
        else if (reinit)
            arm_ff <= 3'h0;
        else if (wr.stb && wr.data == WDOG_ARM)
            arm_ff <= 3'(WDOG_DIS_WIN);
        else if (wr.stb)
            arm_ff <= 3'h0;
        else if (arm_ff != 3'h0)
            arm_ff <= arm_ff - 3'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            ovf    <= 1'b0;
        end else begin
            ovf <= active_ff && !reinit && (cnt_ff == lim);
            if (reinit || kick || cnt_ff == lim)
                cnt_ff <= '0;
            else if (active_ff)
                cnt_ff <= cnt_ff + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wd_default_after: assert property (reinit |=> active_ff
        && ivl_ff == 3'h7 && !lock_ff)
        else $error("watchdog not default after reset");
    a_wd_kick_restart: assert property (!reinit && kick
        |=> cnt_ff == '0 && active_ff)
        else $error("kick did not restart watchdog");
    a_wd_disable_pair: assert property (!reinit && wr.stb
        && wr.data == WDOG_ARM && !lock_ff ##[1:4] (!reinit && wr.stb
        && wr.data == WDOG_DIS) |=> !active_ff)
        else $error("disable pair ignored");
    a_wd_lock_hold: assert property (lock_ff && active_ff && !reinit
        |=> active_ff) else $error("locked watchdog was disabled");
    a_wd_ovf_limit: assert property (ovf
        |-> $past(cnt_ff) == $past(lim))
        else $error("overflow at wrong count");
    c_wd_disabled: cover property (active_ff ##1 !active_ff);

endmodule

//--- src/rsw_top.sv
// Purpose: Reset source controller with cause flags and watchdog.
// Assumes: SYS_RST marks power arrival; analog monitor, comparator and
//          clock-loss one-shot sit outside and report levels.
// Notes:   Core leaves reset at CORE_RST fall, fetching CORE_FETCH_ADDR.
`timescale 1ns/10ps
module rsw_top
    import rsw_pkg::*;
#(
    parameter int POR_CYC  = POR_TIMEOUT_CYC,
    parameter int WDOG_EXP = WDOG_EXP_BASE
) (
    // Clock and reset
    input  wire logic              SYS_CLK,
    input  wire logic              SYS_RST,
    // Wishbone slave
    input  wire logic              WB_CYC_I,
    input  wire logic              WB_STB_I,
    input  wire logic              WB_WE_I,
    input  wire logic [ADR_W-1:0]  WB_ADR_I,
    input  wire logic [3:0]        WB_SEL_I,
    input  wire logic [31:0]       WB_DAT_I,
    output logic [31:0]            WB_DAT_O,
    output logic                   WB_ACK_O,
    // Supply monitor
    input  wire logic              SUPPLY_OK,
    input  wire logic              SUPPLY_MONITOR_ENABLE_PIN,
    // Open-drain reset pin
    input  wire logic              RST_PIN_N_I,
    output logic                   RST_PIN_N_O,
    output logic                   RST_PIN_OE,
    // Other reset sources
    input  wire logic              CLK_MISSING,
    input  wire logic              COMP_OUT,
    input  wire logic              CONVERT_START_N,
    // Detector enable and core control
    output logic                   CLK_DET_EN,
    output logic                   CORE_RST,
    output logic [15:0]            CORE_FETCH_ADDR
);

    localparam int         CW       = $clog2(POR_CYC + 1);
    localparam int         NSYNC    = 6;
    localparam int         I_SUP    = 5;
    localparam int         I_MON    = 4;
    localparam int         I_PIN    = 3;
    localparam int         I_MISS   = 2;
    localparam int         I_COMP   = 1;
    localparam int         I_CNV    = 0;
    // Idle levels: pin, comparator and convert-start rest high
    localparam logic [5:0] SYNC_RST = 6'h0b;

    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    rsw_state_type    st_ff;
    rsw_state_type    nxt_st;
    logic [CW-1:0]    cnt_ff;
    rsw_cause_type    cause_ff;
    rsw_cause_type    nxt_cause;
    logic             loss_en_ff;
    logic             comp_en_ff;
    logic             cnv_en_ff;
    logic             core_rst_ff;
    logic             pin_oe_ff;
    logic             pin_o_ff;
    logic [15:0]      fetch_ff;
    logic             ack_ff;
    logic [31:0]      dat_ff;
    logic             sup_low;
    logic             pin_req;
    logic             loss_req;
    logic             comp_req;
    logic             cnv_req;
    logic             hold_req;
    logic             wd_ovf;
    logic [7:0]       wd_rd;
    logic [7:0]       cause_rd;
    logic             wr_fire;
    rsw_wr_type       wd_wr;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    assign async_in = {SUPPLY_OK, SUPPLY_MONITOR_ENABLE_PIN, RST_PIN_N_I,
                       CLK_MISSING, COMP_OUT, CONVERT_START_N};

    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
        always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
            if (SYS_RST) begin
                meta_ff[i] <= SYNC_RST[i];
                sync_ff[i] <= SYNC_RST[i];
            end else begin
                meta_ff[i] <= async_in[i];
                sync_ff[i] <= meta_ff[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset requests
    assign sup_low  = sync_ff[I_MON] && !sync_ff[I_SUP];
    assign pin_req  = !sync_ff[I_PIN];
    assign loss_req = loss_en_ff && sync_ff[I_MISS];
    assign comp_req = comp_en_ff && !sync_ff[I_COMP];
    assign cnv_req  = cnv_en_ff && !sync_ff[I_CNV];
    assign hold_req = pin_req || loss_req || comp_req || cnv_req;

    always_comb begin
        nxt_st    = st_ff;
        nxt_cause = '0;
        unique case (st_ff)
            ST_POR: begin
                if (!sup_low && cnt_ff == '0)
                    nxt_st = ST_STRETCH;
            end
            ST_STRETCH: begin
                if (sup_low)
                    nxt_st = ST_POR;
                else if (cnt_ff == '0 && !hold_req)
                    nxt_st = ST_RUN;
            end
            ST_RUN: begin
                if (sup_low)
                    nxt_st = ST_POR;
                else if (hold_req || wd_ovf)
                    nxt_st = ST_STRETCH;
            end
            default: nxt_st = ST_POR;
        endcase
        // Fixed priority keeps the latched cause one-hot
        if (pin_req)
            nxt_cause.pin = 1'b1;
        else if (loss_req)
            nxt_cause.loss = 1'b1;
        else if (comp_req)
            nxt_cause.comp = 1'b1;
        else if (cnv_req)
            nxt_cause.cnv = 1'b1;
        else
            nxt_cause.wdog = 1'b1;
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            st_ff <= ST_POR;
        else
            st_ff <= nxt_st;
    end

    // One counter serves both the long supply timeout and the pin stretch
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            cnt_ff <= CW'(POR_CYC - 1);
        else if (nxt_st == ST_POR && (st_ff != ST_POR || sup_low))
            cnt_ff <= CW'(POR_CYC - 1);
        else if (nxt_st == ST_STRETCH && (st_ff != ST_STRETCH || hold_req))
            cnt_ff <= CW'(PIN_HOLD_CYC);
        else if (cnt_ff != '0)
            cnt_ff <= cnt_ff - 1'b1;
    end

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST)
            cause_ff <= '0;
        else if (st_ff == ST_POR && nxt_st == ST_STRETCH)
            cause_ff <= '{por: 1'b1, default: 1'b0};
        else if (st_ff == ST_RUN && nxt_st == ST_STRETCH)
            cause_ff <= nxt_cause;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs toward pin, detector and core
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pin_oe_ff   <= 1'b1;
            pin_o_ff    <= 1'b0;
            core_rst_ff <= 1'b1;
            fetch_ff    <= RESET_VECTOR;
        end else begin
            // Only the supply path drives the pin
            pin_oe_ff   <= (nxt_st == ST_POR);
            pin_o_ff    <= 1'b0;
            core_rst_ff <= (nxt_st != ST_RUN);
            fetch_ff    <= RESET_VECTOR;
        end
    end

    assign RST_PIN_OE      = pin_oe_ff;
    assign RST_PIN_N_O     = pin_o_ff;
    assign CORE_RST        = core_rst_ff;
    assign CORE_FETCH_ADDR = fetch_ff;
    assign CLK_DET_EN      = loss_en_ff;

    ////////////////////////////////////////////////////////////////////////
    // Wishbone slave: ack one cycle after request, write at the ack edge
    assign wr_fire = WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff && WB_SEL_I[0];

    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ack_ff <= 1'b0;
            dat_ff <= '0;
        end else begin
            ack_ff <= WB_CYC_I && WB_STB_I && !ack_ff;
            if (WB_CYC_I && WB_STB_I && !ack_ff) begin
                unique case (WB_ADR_I)
                    WDOG_CTRL_OFS: dat_ff <= {24'h0, wd_rd};
                    CAUSE_OFS:     dat_ff <= {24'h0, cause_rd};
                    default:       dat_ff <= '0;
                endcase
            end
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = dat_ff;

    always_comb begin
        cause_rd                 = 8'h00;
        cause_rd[CAUSE_PIN_BIT]  = cause_ff.pin;
        cause_rd[CAUSE_POR_BIT]  = cause_ff.por;
        cause_rd[CAUSE_LOSS_BIT] = cause_ff.loss;
        cause_rd[CAUSE_WDOG_BIT] = cause_ff.wdog;
        cause_rd[CAUSE_COMP_BIT] = cause_ff.comp;
        cause_rd[CAUSE_CNV_BIT]  = cause_ff.cnv;
    end

    // Enables survive the resets they cause so a held level keeps reset on
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            loss_en_ff <= 1'b0;
            comp_en_ff <= 1'b0;
            cnv_en_ff  <= 1'b0;
        end else if (st_ff == ST_POR) begin
            loss_en_ff <= 1'b0;
            comp_en_ff <= 1'b0;
            cnv_en_ff  <= 1'b0;
        end else if (wr_fire && WB_ADR_I == CAUSE_OFS && !core_rst_ff) begin
            loss_en_ff <= WB_DAT_I[CAUSE_LOSS_BIT];
            comp_en_ff <= WB_DAT_I[CAUSE_COMP_BIT];
            cnv_en_ff  <= WB_DAT_I[CAUSE_CNV_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog
    assign wd_wr.stb  = wr_fire && WB_ADR_I == WDOG_CTRL_OFS && !core_rst_ff;
    assign wd_wr.data = WB_DAT_I[7:0];

    rsw_wdog #(
        .CNT_BITS (WDOG_BITS),
        .EXP_BASE (WDOG_EXP)
    ) u_wdog (
        .clk     (SYS_CLK),
        .rst     (SYS_RST),
        .reinit  (core_rst_ff),
        .wr      (wd_wr),
        .ctrl_rd (wd_rd),
        .ovf     (wd_ovf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    a_pin_drive_por: assert property (st_ff == ST_POR |-> RST_PIN_OE
        && !RST_PIN_N_O) else $error("pin not driven in supply reset");
    a_supply_enters_por: assert property (sup_low |=> st_ff == ST_POR
        && CORE_RST) else $error("supply low did not reset");
    a_monitor_off_quiet: assert property (!sup_low && st_ff != ST_POR
        |=> st_ff != ST_POR) else $error("reset without monitor");
    a_pin_stretch_min: assert property ($rose(sync_ff[I_PIN])
        && st_ff == ST_STRETCH |-> CORE_RST [*8] ##1 CORE_RST [*4])
        else $error("pin reset released early");
    a_por_flag_set: assert property (st_ff == ST_POR
        ##1 st_ff == ST_STRETCH |-> cause_ff.por && !cause_ff.pin)
        else $error("power-on flag not set");
    a_por_flag_clear: assert property (st_ff == ST_RUN
        ##1 st_ff == ST_STRETCH |-> !cause_ff.por)
        else $error("power-on flag kept");
    a_wdog_no_pin: assert property (wd_ovf && st_ff == ST_RUN
        && !sup_low |=> st_ff == ST_STRETCH && !RST_PIN_OE)
        else $error("watchdog reset wrong");
    a_comp_cause: assert property (comp_req && !pin_req && !loss_req
        && !sup_low && st_ff == ST_RUN |=> cause_ff.comp && !RST_PIN_OE)
        else $error("comparator reset wrong");
    a_cnv_cause: assert property (cnv_req && !comp_req && !pin_req
        && !loss_req && !sup_low && st_ff == ST_RUN |=> cause_ff.cnv
        && !RST_PIN_OE) else $error("convert-start reset wrong");
    a_fetch_vector: assert property ($fell(CORE_RST)
        |-> CORE_FETCH_ADDR == RESET_VECTOR)
        else $error("bad start address");

    // Level sources keep the core held for as long as they stay active
    a_core_held: assert property (st_ff != ST_RUN |-> CORE_RST)
        else $error("core released outside run");
    a_pin_only_supply: assert property (st_ff != ST_POR
        |-> !RST_PIN_OE) else $error("pin driven by non-supply reset");
    a_pin_cause: assert property (pin_req && !sup_low
        && st_ff == ST_RUN |=> cause_ff.pin && CORE_RST)
        else $error("pin reset cause wrong");
    a_loss_cause: assert property (loss_req && !pin_req && !sup_low
        && st_ff == ST_RUN |=> cause_ff.loss && !RST_PIN_OE)
        else $error("clock-loss reset wrong");
    a_loss_enable: assert property (wr_fire && WB_ADR_I == CAUSE_OFS
        && !core_rst_ff |=> CLK_DET_EN == $past(WB_DAT_I[CAUSE_LOSS_BIT]))
        else $error("clock-loss enable not written");
    a_comp_level: assert property (comp_req && !sup_low
        && st_ff != ST_POR |=> CORE_RST) else $error("comparator ignored");
    a_cnv_level: assert property (cnv_req && !sup_low
        && st_ff != ST_POR |=> CORE_RST) else $error("convert-start ignored");
    a_cause_onehot: assert property (st_ff == ST_RUN
        |-> $onehot(cause_rd)) else $error("cause flags not one-hot");
    a_wdog_cause: assert property (wd_ovf && !hold_req && !sup_low
        && st_ff == ST_RUN |=> cause_ff.wdog)
        else $error("watchdog cause wrong");

    c_por_release: cover property (st_ff == ST_POR ##[1:300] st_ff == ST_RUN);
    c_pin_reset: cover property (st_ff == ST_RUN ##1 cause_ff.pin);
    c_wdog_reset: cover property (wd_ovf ##1 cause_ff.wdog);
    c_loss_reset: cover property (st_ff == ST_RUN ##1 cause_ff.loss);

endmodule

//--- test/rsw_pin_model.sv
// Purpose: Far side of the reset pin: pull-up plus an external button.
// Assumes: The device drives the pin open drain.
// Notes:   Pin reads high unless someone pulls it low.
`timescale 1ns/10ps
module rsw_pin_model (
    // Device side
    input  wire logic pin_oe,
    input  wire logic pin_o,
    // Bench command
    input  wire logic press,
    // Resolved pin level
    output logic      pin_n
);
    // Pull-up, so a released pin never shows a stale low
    assign pin_n = ((pin_oe && !pin_o) || press) ? 1'b0 : 1'b1;
endmodule

//--- test/tb.sv
// Purpose: Self-checking bench for the reset source controller.
// Assumes: POR_CYC 20 and WDOG_EXP 0 shorten the long counts.
// Notes:   Bus tasks wait for ack; a cycle ceiling ends a hang.
`timescale 1ns/10ps
module tb;
    import rsw_pkg::*;
    localparam int POR = 20;
    logic        clk, rst, cyc, we, ok, mon, press, miss, cmp, cnv;
    logic [3:0]  adr, sel;
    logic [31:0] dwr, drd;
    logic        ack, oe, po, pin, det, core;
    logic [15:0] fetch;
    logic [7:0]  en [4] = '{8'h00, 8'h04, 8'h20, 8'h40};
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cycles = 0;

    rsw_top #(.POR_CYC(POR), .WDOG_EXP(0)) DUT (
        .SYS_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dwr),
        .WB_DAT_O(drd), .WB_ACK_O(ack), .SUPPLY_OK(ok),
        .SUPPLY_MONITOR_ENABLE_PIN(mon), .RST_PIN_N_I(pin),
        .RST_PIN_N_O(po), .RST_PIN_OE(oe), .CLK_MISSING(miss),
        .COMP_OUT(cmp), .CONVERT_START_N(cnv), .CLK_DET_EN(det),
        .CORE_RST(core), .CORE_FETCH_ADDR(fetch));
    rsw_pin_model u_pin (.pin_oe(oe), .pin_o(po), .press(press),
                         .pin_n(pin));

    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Whole run is near 500 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles > 5000) begin
            error_cnt++;
            stop_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [7:0] d, output logic [31:0] q);
        cyc <= 1'b1;
        we  <= w;
        adr <= a;
        dwr <= {24'h0, d};
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        q = drd;
        cyc <= 1'b0;
        we  <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    task automatic wait_core(input logic v, output int n);
        n = 0;
        while (core !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic cnt_oe(output int n);
        n = 0;
        while (oe === 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic rel();
        int n;
        wait_core(1'b0, n);
        check(core, 1'b0);
        check(fetch, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        rst = 1'b1;
        {cyc, we, adr, dwr, press, miss} = '0;
        {ok, mon, cmp, cnv} = 4'hf;
        sel = 4'h1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cnt_oe(n);
        check(n >= POR, 1'b1);
        rel();
        rd(CAUSE_OFS, 32'h02);
        rd(WDOG_CTRL_OFS, 32'h17);
        rd(4'h8, 32'h0);
        wr(WDOG_CTRL_OFS, WDOG_ARM);
        wr(WDOG_CTRL_OFS, WDOG_DIS);
        rd(WDOG_CTRL_OFS, 32'h07);
        wr(WDOG_CTRL_OFS, 8'h03);
        rd(WDOG_CTRL_OFS, 32'h03);
        wr(WDOG_CTRL_OFS, 8'h81);
        rd(WDOG_CTRL_OFS, 32'h03);
        // A write without its byte lane must leave the interval alone
        sel <= 4'h0;
        wr(WDOG_CTRL_OFS, 8'h01);
        sel <= 4'h1;
        rd(WDOG_CTRL_OFS, 32'h03);
        wr(WDOG_CTRL_OFS, WDOG_KICK);
        rd(WDOG_CTRL_OFS, 32'h13);
        // Kicks inside the 64-cycle interval keep the core running
        repeat (3) begin
            repeat (45) @(posedge clk);
            wr(WDOG_CTRL_OFS, WDOG_KICK);
        end
        rd(WDOG_CTRL_OFS, 32'h13);
        wr(WDOG_CTRL_OFS, WDOG_ARM);
        repeat (3) @(posedge clk);
        wr(WDOG_CTRL_OFS, WDOG_DIS);
        rd(WDOG_CTRL_OFS, 32'h13);
        wait_core(1'b1, n);
        check(n > 30 && n < 70, 1'b1);
        check(oe, 1'b0);
        rel();
        rd(CAUSE_OFS, 32'h08);
        rd(WDOG_CTRL_OFS, 32'h17);
        wr(WDOG_CTRL_OFS, WDOG_LOCK);
        wr(WDOG_CTRL_OFS, WDOG_ARM);
        wr(WDOG_CTRL_OFS, WDOG_DIS);
        rd(WDOG_CTRL_OFS, 32'h17);
        // Pin, clock loss, comparator, convert-start in turn
        for (int k = 0; k < 4; k++) begin
            // Comparator already idles high before its reset is enabled
            wr(CAUSE_OFS, en[k]);
            check(det, k == 1);
            press <= (k == 0);
            miss  <= (k == 1);
            cmp   <= (k != 2);
            cnv   <= (k != 3);
            wait_core(1'b1, n);
            check(oe, 1'b0);
            {press, miss} <= 2'b00;
            {cmp, cnv}    <= 2'b11;
            wait_core(1'b0, n);
            check(n >= PIN_HOLD_CYC, 1'b1);
            rel();
            rd(CAUSE_OFS, k == 0 ? 32'h01 : {24'h0, en[k]});
        end
        // Monitor disabled: a low supply is ignored
        mon <= 1'b0;
        ok  <= 1'b0;
        repeat (30) @(posedge clk);
        check(core, 1'b0);
        ok  <= 1'b1;
        mon <= 1'b1;
        repeat (4) @(posedge clk);
        ok <= 1'b0;
        repeat (10) @(posedge clk);
        check(oe, 1'b1);
        check(po, 1'b0);
        ok <= 1'b1;
        cnt_oe(n);
        check(n >= POR, 1'b1);
        rel();
        rd(CAUSE_OFS, 32'h02);
        stop_test();
    end
endmodule
